/* File: hdl/lps_pkg.sv */
// constants and types shared by the lock pulse sequencer
package lps_pkg;
	// apb register byte offsets
	localparam logic [7:0] LPS_CTRL_OFS   = 8'h00;  // control bits
	localparam logic [7:0] LPS_STAT_OFS   = 8'h04;  // live sequencer state
	localparam logic [7:0] LPS_MADDR_OFS  = 8'h08;  // pulse memory index
	localparam logic [7:0] LPS_MDATA_OFS  = 8'h0c;  // pulse memory word port
	localparam logic [7:0] LPS_PRESET_OFS = 8'h10;  // counter preset value
	// control register fields
	localparam int LPS_CTRL_TXEN = 0;  // software transmitter blank enable
	localparam int LPS_CTRL_RXEN = 1;  // software receiver blank enable
	localparam int LPS_CTRL_FAST = 2;  // fast field adjust line
	localparam int LPS_CTRL_ALT  = 3;  // alternate lock substance line
	localparam int LPS_CTRL_REV  = 4;  // board revision level, 3 bits
	localparam logic [6:0] LPS_CTRL_RST = 7'h00;
	// pulse word layout
	localparam int LPS_W_SHAPE = 0;   // 7-bit shape, bits 6..0
	localparam int LPS_W_TX    = 7;   // transmit pulse
	localparam int LPS_W_RX    = 8;   // receive pulse
	localparam int LPS_W_PHASE = 9;   // 1 = receive phase register
	localparam int LPS_W_CLR   = 10;  // clear counter at next step
	localparam int LPS_W_PRE   = 11;  // preset counter at next step
	localparam int LPS_WORD_W  = 12;
	localparam int LPS_MEM_AW  = 15;  // set(2) bank(2) upper(1) count(10)
	// counter limits
	localparam logic [10:0] LPS_LIM_2K = 11'h7ff;
	localparam logic [10:0] LPS_LIM_1K = 11'h3ff;
	localparam logic [2:0]  LPS_REV_SPLIT = 3'h2;  // 10-bit counter from here
	localparam logic [2:0]  LPS_REV_SETS  = 3'h5;  // set selector from here
	// timing
	localparam int LPS_REF_HZ  = 10_000_000;  // reference frequency
	localparam int LPS_STEP_HZ = 1_000_000;   // counter step rate
	localparam logic [3:0] LPS_REF_DIV = 4'(LPS_REF_HZ / LPS_STEP_HZ);
	// synthesizer: 60 MHz over 2^32 gives 14 mHz steps
	localparam int LPS_SYN_HZ   = 60_000_000;
	localparam int LPS_FREQ_W   = 32;
	localparam int LPS_PHASE_W  = 12;
	// serial control bus targets
	localparam logic [2:0] LPS_CB_LEVEL = 3'h1;
	localparam logic [2:0] LPS_CB_FREQ  = 3'h2;
	localparam logic [2:0] LPS_CB_PHASE = 3'h3;
	// lock modes, one per pulse bank
	typedef enum logic [3:0] {
		LPS_M_RESET  = 4'b0001,
		LPS_M_FAST   = 4'b0010,
		LPS_M_NORMAL = 4'b0100,
		LPS_M_DIAG   = 4'b1000
	} lps_mode_t;
endpackage

/* File: hdl/lps_sequencer.sv */
// lock pulse sequencer: pulse memory, address counter, blanking, serial control
//
// Summary of operation
// R1 - one pulse bank per lock mode, active played
// R2 - each bank at most 2K words
// R3 - bank chosen by serially loaded shift register
// R4 - central logic combines bank, word, count, blanking
// R5 - normal mode: blank inputs switch receiver, transmitter
// R6 - early revisions: 11-bit counter over 2K
// R7 - counter steps at 1 MHz from 10 MHz
// R8 - clear or preset by mode and count
// R9 - revision 02 on: 10-bit counter over 1K
// R10 - upper bit low plays lower normal half
// R11 - upper bit high plays blank half
// R12 - upper bit is blank input AND enable
// R13 - no shape while normal mode transmit blanked
// R14 - revision 05 on: four sets, panel selects
// R15 - 7-bit shape bus from pulse memory
// R16 - fast adjust powers and routes amplifier
// R17 - alternate substance turns deuterium signals off
// R18 - two phase registers, fast switch
// R19 - 60 MHz synthesizer, 14 mHz step word
// R20 - serial bus loads 8-bit shift registers
// R21 - enable and bank take effect at restart
`timescale 1ns/1ps
module lps_sequencer
	import lps_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// pins from outside the clock domain
	input  wire logic                   ref_clk_in,
	input  wire logic [2:0]             bank_select_lines,
	input  wire logic                   receive_blank_in,
	input  wire logic                   transmit_blank_in,
	input  wire logic [1:0]             pulse_set_sel,
	input  wire logic                   ctl_data,
	input  wire logic                   ctl_clk,
	input  wire logic                   ctl_wr,
	input  wire logic [2:0]             ctl_addr,
	// outputs
	output logic                        step_tick,
	output logic                        tx_pulse,
	output logic                        rx_pulse,
	output logic [6:0]                  shape_word_bus,
	output logic                        blank_bank_select,
	output logic                        phase_sel,
	output logic [LPS_PHASE_W-1:0]      synth_phase_word,
	output logic [LPS_FREQ_W-1:0]       synth_freq_word,
	output logic [7:0]                  level_control_voltage,
	output logic                        fast_amp_power,
	output logic                        tx_route_fast,
	output logic                        tx_route_normal,
	output logic                        d2_tx_enable,
	output logic                        d2_lo_enable
);

	// bank index to one-hot lock mode
	function automatic lps_mode_t mode_of(input logic [1:0] b);
		unique case (b)
			2'h0: mode_of = LPS_M_RESET;
			2'h1: mode_of = LPS_M_FAST;
			2'h2: mode_of = LPS_M_NORMAL;
			2'h3: mode_of = LPS_M_DIAG;
		endcase
	endfunction

	// rising edge of a synchronised level
	function automatic logic rise(input logic now, input logic was);
		rise = now & ~was;
	endfunction

	// two-flop synchronisers for every asynchronous pin
	localparam int SW = 14;
	logic [SW-1:0] pin_raw;   // pins gathered
	logic [SW-1:0] sync1_q;   // first stage, read only by sync2
	logic [SW-1:0] sync2_q;   // safe copy
	logic [SW-1:0] prev_q;    // one more cycle for edge detection
	assign pin_raw = {ctl_addr, ctl_wr, ctl_clk, ctl_data, pulse_set_sel,
	                  transmit_blank_in, receive_blank_in, bank_select_lines,
	                  ref_clk_in};

	// synchroniser chain
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	logic       ref_s, bsel_dat, bsel_clk, bsel_ld, rxb_s, txb_s;
	logic [1:0] set_s;
	logic       cb_dat, cb_clk, cb_wr;
	logic [2:0] cb_adr;
	assign ref_s    = sync2_q[0];
	assign bsel_dat = sync2_q[1];
	assign bsel_clk = sync2_q[2];
	assign bsel_ld  = sync2_q[3];
	assign rxb_s    = sync2_q[4];
	assign txb_s    = sync2_q[5];
	assign set_s    = sync2_q[7:6];
	assign cb_dat   = sync2_q[8];
	assign cb_clk   = sync2_q[9];
	assign cb_wr    = sync2_q[10];
	assign cb_adr   = sync2_q[13:11];

	// software registers
	logic [6:0]            ctrl_q;     // control bits
	logic [LPS_MEM_AW-1:0] maddr_q;    // memory access index
	logic [10:0]           preset_q;   // preset count
	logic [LPS_WORD_W-1:0] mem [2**LPS_MEM_AW];  // pulse memory, all banks and sets
	logic [2:0]            rev;
	logic                  rev_split, rev_sets;
	assign rev       = ctrl_q[LPS_CTRL_REV +: 3];
	assign rev_split = (rev >= LPS_REV_SPLIT);
	assign rev_sets  = (rev >= LPS_REV_SETS);

	// apb decode; zero wait states, read data latched in the setup cycle
	logic apb_setup, apb_wr, hit;
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign pready    = 1'b1;
	always_comb begin
		unique case (paddr)
			LPS_CTRL_OFS, LPS_STAT_OFS, LPS_MADDR_OFS,
			LPS_MDATA_OFS, LPS_PRESET_OFS: hit = 1'b1;
			default:                       hit = 1'b0;  // unmapped
		endcase
	end
	assign pslverr = psel & penable & ~hit;

	// control, index and preset registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q   <= LPS_CTRL_RST;
			maddr_q  <= '0;
			preset_q <= '0;
		end else if (apb_wr) begin
			unique case (paddr)
				LPS_CTRL_OFS:   ctrl_q   <= pwdata[6:0];
				LPS_MADDR_OFS:  maddr_q  <= pwdata[LPS_MEM_AW-1:0];
				LPS_PRESET_OFS: preset_q <= pwdata[10:0];
				// a data write steps the index so banks load as a stream
				LPS_MDATA_OFS:  maddr_q  <= maddr_q + 1'b1;
				default:        ;
			endcase
		end
	end

	// pulse memory writes; no reset, contents are software loaded
	always_ff @(posedge mclk) begin
		if (apb_wr && paddr == LPS_MDATA_OFS)
			mem[maddr_q] <= pwdata[LPS_WORD_W-1:0];  // see R1
	end

	// bank select shift register, shifted by the controller; see R3
	logic [1:0] bsel_sh_q;   // serial shift stage, last two bits shifted
	logic [1:0] bank_req_q;  // latched request from the controller
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bsel_sh_q  <= '0;
			bank_req_q <= '0;
		end else begin
			if (rise(bsel_clk, prev_q[2]))
				bsel_sh_q <= {bsel_sh_q[0], bsel_dat};    // see R3
			if (rise(bsel_ld, prev_q[3]))
				bank_req_q <= bsel_sh_q;                  // see R3
		end
	end

	// 1 MHz step tick from reference edges; see R7
	logic [3:0] div_q;
	logic       tick;
	assign tick = rise(ref_s, prev_q[0]) && (div_q == LPS_REF_DIV - 4'h1);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			div_q <= '0;
		else if (rise(ref_s, prev_q[0]))
			div_q <= tick ? 4'h0 : div_q + 4'h1;  // see R7
	end

	// address counter and restart shadows
	logic [10:0]           cnt_q;    // counter value
	logic [1:0]            bank_q;   // active bank, updated on restart
	logic                  txen_q;   // shadow of transmit blank enable
	logic [1:0]            set_q;    // active pulse set
	logic [LPS_WORD_W-1:0] word_q;   // word being played
	lps_mode_t             mode;
	logic [10:0]           lim;
	logic                  restart, do_pre;
	assign mode    = mode_of(bank_q);
	assign lim     = rev_split ? LPS_LIM_1K : LPS_LIM_2K;  // see R6 see R9
	// central logic: reset mode holds the count clear, words ask for
	// clear or preset, and the end of the range wraps; see R8 see R4
	assign do_pre  = word_q[LPS_W_PRE] && (mode != LPS_M_RESET);
	assign restart = (mode == LPS_M_RESET) || word_q[LPS_W_CLR] ||
	                 do_pre || (cnt_q >= lim);

	// counter steps only on the tick
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q  <= '0;
			bank_q <= '0;
			txen_q <= 1'b0;
			set_q  <= '0;
		end else if (tick) begin
			if (restart) begin
				cnt_q  <= do_pre ? (preset_q & lim) : 11'h000;  // see R8
				// new selections wait for the sweep start so a bank
				// never changes in mid-pattern
				bank_q <= bank_req_q;                           // see R21
				txen_q <= ctrl_q[LPS_CTRL_TXEN];                // see R21
				set_q  <= rev_sets ? set_s : 2'h0;              // see R14
			end else begin
				cnt_q  <= cnt_q + 11'h001;                      // see R6 see R9
			end
		end
	end

	// memory address: upper bit from counter or from blanking
	logic                  blank_sel, upper;
	logic [LPS_MEM_AW-1:0] play_addr;
	assign blank_sel = txb_s & txen_q;                       // see R12
	assign upper     = rev_split ? blank_sel : cnt_q[10];    // see R10 see R11
	assign play_addr = {set_q, bank_q, upper, cnt_q[9:0]};   // see R2 see R14

	// fetch the word; a one-cycle delay against a microsecond step
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			word_q <= '0;
		else
			word_q <= mem[play_addr];  // see R1
	end

	// blanking qualified by the software enables
	logic tx_blk, rx_blk, normal;
	assign normal = (mode == LPS_M_NORMAL);
	assign tx_blk = normal & txb_s & txen_q;
	assign rx_blk = normal & rxb_s & ctrl_q[LPS_CTRL_RXEN];

	// pulse outputs
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_pulse          <= 1'b0;
			rx_pulse          <= 1'b0;
			shape_word_bus    <= '0;
			blank_bank_select <= 1'b0;
			phase_sel         <= 1'b0;
			step_tick         <= 1'b0;
		end else begin
			tx_pulse          <= word_q[LPS_W_TX] & ~tx_blk;  // see R5
			rx_pulse          <= word_q[LPS_W_RX] & ~rx_blk;  // see R5
			shape_word_bus    <= tx_blk ? 7'h00 :
			                     word_q[LPS_W_SHAPE +: 7];    // see R13 see R15
			blank_bank_select <= rev_split & blank_sel;       // see R12
			phase_sel         <= word_q[LPS_W_PHASE];         // see R18
			step_tick         <= tick;
		end
	end

	// mode control lines
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fast_amp_power  <= 1'b0;
			tx_route_fast   <= 1'b0;
			tx_route_normal <= 1'b1;
			d2_tx_enable    <= 1'b0;
			d2_lo_enable    <= 1'b0;
		end else begin
			fast_amp_power  <= ctrl_q[LPS_CTRL_FAST];   // see R16
			tx_route_fast   <= ctrl_q[LPS_CTRL_FAST];   // see R16
			tx_route_normal <= ~ctrl_q[LPS_CTRL_FAST];  // see R16
			d2_tx_enable    <= ~ctrl_q[LPS_CTRL_ALT];  // see R17
			d2_lo_enable    <= ~ctrl_q[LPS_CTRL_ALT];  // see R17
		end
	end

	// serial control bus: msb first on clock rise, commit on write rise
	logic [7:0]                cb_sh_q;   // 8-bit serial to parallel
	logic [2*LPS_PHASE_W-1:0]  phase_q;   // transmit and receive phases
	logic                      cb_commit;
	assign cb_commit = rise(cb_wr, prev_q[10]);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cb_sh_q               <= '0;
			phase_q               <= '0;
			synth_freq_word       <= '0;
			level_control_voltage <= '0;
		end else begin
			if (rise(cb_clk, prev_q[9]))
				cb_sh_q <= {cb_sh_q[6:0], cb_dat};                  // see R20
			if (cb_commit) begin
				unique case (cb_adr)
					LPS_CB_LEVEL: level_control_voltage <= cb_sh_q;  // see R20
					// wide words are built a byte at a time
					LPS_CB_FREQ:  synth_freq_word <=
					              {synth_freq_word[LPS_FREQ_W-9:0], cb_sh_q};  // see R19
					LPS_CB_PHASE: phase_q <=
					              {phase_q[2*LPS_PHASE_W-9:0], cb_sh_q};       // see R18
					default:      ;  // other targets are not on this block
				endcase
			end
		end
	end
	// phase register switch follows the pulse word, no reprogramming;
	// registered from the same word bit as phase_sel so both move together
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			synth_phase_word <= '0;
		else if (word_q[LPS_W_PHASE])
			synth_phase_word <= phase_q[2*LPS_PHASE_W-1:LPS_PHASE_W];  // see R18
		else
			synth_phase_word <= phase_q[LPS_PHASE_W-1:0];              // see R18
	end

	// register read data, captured during the setup cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			prdata <= '0;
		else if (apb_setup) begin
			unique case (paddr)
				LPS_CTRL_OFS:   prdata <= {25'h0, ctrl_q};
				LPS_STAT_OFS:   prdata <= {14'h0, blank_sel, set_q, bank_req_q,
				                           bank_q, cnt_q};
				LPS_MADDR_OFS:  prdata <= {17'h0, maddr_q};
				LPS_MDATA_OFS:  prdata <= {20'h0, mem[maddr_q]};
				LPS_PRESET_OFS: prdata <= {21'h0, preset_q};
				default:        prdata <= '0;
			endcase
		end
	end

	// checks
	sequence s_step_restart;
		tick && restart && !do_pre;
	endsequence
	sequence s_cb_level;
		cb_commit && cb_adr == LPS_CB_LEVEL;
	endsequence

	a_cnt_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
		s_step_restart |=> cnt_q == 11'h000)  // see R8
		else $error("counter not cleared on restart");
	a_cnt_step: assert property (@(posedge mclk) disable iff (sys_rst)
		tick && !restart |=> cnt_q == $past(cnt_q) + 11'h001)  // see R7
		else $error("counter did not step by one");
	a_cnt_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!tick |=> $stable(cnt_q))  // see R7
		else $error("counter moved without a step tick");
	a_cnt_range: assert property (@(posedge mclk) disable iff (sys_rst)
		rev_split && $stable(rev) |=> cnt_q <= LPS_LIM_1K || $past(cnt_q) > LPS_LIM_1K)  // see R9
		else $error("counter left the 1K range");
	a_blank_bank: assert property (@(posedge mclk) disable iff (sys_rst)
		rev_split && txb_s && txen_q |=> blank_bank_select)  // see R12
		else $error("blank bank select not asserted");
	a_shape_off: assert property (@(posedge mclk) disable iff (sys_rst)
		tx_blk |=> shape_word_bus == 7'h00 && !tx_pulse)  // see R13
		else $error("shape present while transmit blanked");
	a_rx_blank: assert property (@(posedge mclk) disable iff (sys_rst)
		rx_blk |=> !rx_pulse)  // see R5
		else $error("receive pulse while receive blanked");
	a_fast_route: assert property (@(posedge mclk) disable iff (sys_rst)
		ctrl_q[LPS_CTRL_FAST] [*2] |-> fast_amp_power && tx_route_fast && !tx_route_normal)  // see R16
		else $error("fast adjust routing wrong");
	a_subst_off: assert property (@(posedge mclk) disable iff (sys_rst)
		ctrl_q[LPS_CTRL_ALT] |=> !d2_tx_enable && !d2_lo_enable)  // see R17
		else $error("deuterium signals on with alternate substance");
	a_level_load: assert property (@(posedge mclk) disable iff (sys_rst)
		s_cb_level |=> level_control_voltage == $past(cb_sh_q))  // see R20
		else $error("level byte not loaded");
	a_bank_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(tick && restart) |=> $stable(bank_q) && $stable(txen_q))  // see R21
		else $error("bank changed outside a restart");

endmodule // lps_sequencer

/* File: dv/lps_far_end.sv */
// far-side model: free reference clock, lock controller serial lines, blanking source
`timescale 1ns/1ps
module lps_far_end (
	input  wire logic       mclk,
	output logic            ref_clk_in,
	output logic [2:0]      bank_select_lines,
	output logic            receive_blank_in,
	output logic            transmit_blank_in,
	output logic            ctl_data,
	output logic            ctl_clk,
	output logic            ctl_wr,
	output logic [2:0]      ctl_addr
);
	logic [3:0] ref_cnt_q;  // mclk cycles since the last reference edge
	// every pin has a level at time zero
	initial begin
		ref_cnt_q = 4'h0;
		ref_clk_in = 1'b0;
		bank_select_lines = 3'h0;
		{receive_blank_in, transmit_blank_in} = 2'h0;
		{ctl_data, ctl_clk, ctl_wr} = 3'h0;
		ctl_addr = 3'h0;
	end
	// reference runs free at 10 mhz: a toggle every ten 5 ns cycles
	always @(posedge mclk) begin
		if (ref_cnt_q == 4'h9) begin
			ref_cnt_q <= 4'h0;
			ref_clk_in <= ~ref_clk_in;
		end else begin
			ref_cnt_q <= ref_cnt_q + 4'h1;
		end
	end
	// each level stands 4 cycles, above the 3 the synchronisers need
	task automatic hold();
		repeat (4) @(posedge mclk);
	endtask
	// bank code msb first, then the load edge; lsb is the last bit shifted
	task automatic send_bank(input logic [1:0] b);
		for (int i = 1; i >= 0; i--) begin
			bank_select_lines[0] <= b[i];
			hold();
			bank_select_lines[1] <= 1'b1;
			hold();
			bank_select_lines[1] <= 1'b0;
			hold();
		end
		bank_select_lines[2] <= 1'b1;
		hold();
		bank_select_lines[2] <= 1'b0;
		// released data line shows the inverse so a stale level is never trusted
		bank_select_lines[0] <= ~b[0];
		hold();
	endtask
	// one byte msb first on the serial control bus, committed to target a
	task automatic ctl_send(input logic [2:0] a, input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			ctl_data <= d[i];
			hold();
			ctl_clk <= 1'b1;
			hold();
			ctl_clk <= 1'b0;
			hold();
		end
		ctl_addr <= a;
		hold();
		ctl_wr <= 1'b1;
		hold();
		ctl_wr <= 1'b0;
		ctl_data <= ~d[0];
		hold();
	endtask
	// real-time blanking levels
	task automatic set_blank(input logic tx, input logic rx);
		transmit_blank_in <= tx;
		receive_blank_in <= rx;
		hold();
	endtask
endmodule // lps_far_end

/* File: dv/tb.sv */
// self-checking bench for the lock pulse sequencer
`timescale 1ns/1ps
module tb;
	import lps_pkg::*;
	logic                   mclk = 1'b0, sys_rst = 1'b1;
	logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0, prdata;
	logic                   ref_clk_in, receive_blank_in, transmit_blank_in;
	logic [2:0]             bank_select_lines, ctl_addr;
	logic                   ctl_data, ctl_clk, ctl_wr;
	logic [1:0]             pulse_set_sel = 2'h0;  // front panel set switch
	logic                   step_tick, tx_pulse, rx_pulse, blank_bank_select, phase_sel;
	logic [6:0]             shape_word_bus;
	logic [LPS_PHASE_W-1:0] synth_phase_word;
	logic [LPS_FREQ_W-1:0]  synth_freq_word;
	logic [7:0]             level_control_voltage;
	logic                   fast_amp_power, tx_route_fast, tx_route_normal;
	logic                   d2_tx_enable, d2_lo_enable;
	// expected state held by the bench
	logic [1:0]             e_bank = 2'h0, e_set = 2'h0;
	logic [2:0]             rev = 3'h2;
	logic                   txb = 1'b0, rxb = 1'b0, txen = 1'b1, rxen = 1'b1;
	logic                   sh_en = 1'b0, fast = 1'b0, alt = 1'b0, e;
	logic [11:0]            ph_lo = 12'h0, ph_hi = 12'h0;
	logic [31:0]            q;
	logic [9:0]             cl [7] = '{10'h0, 10'h1, 10'h2, 10'h3, 10'h3fd, 10'h3fe, 10'h3ff};
	int                     miscompares = 0, n_tests = 0;
	lps_sequencer uut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ref_clk_in, .bank_select_lines, .receive_blank_in,
		.transmit_blank_in, .pulse_set_sel, .ctl_data, .ctl_clk, .ctl_wr, .ctl_addr,
		.step_tick, .tx_pulse, .rx_pulse, .shape_word_bus, .blank_bank_select, .phase_sel,
		.synth_phase_word, .synth_freq_word, .level_control_voltage, .fast_amp_power,
		.tx_route_fast, .tx_route_normal, .d2_tx_enable, .d2_lo_enable);
	lps_far_end far (.mclk, .ref_clk_in, .bank_select_lines, .receive_blank_in,
		.transmit_blank_in, .ctl_data, .ctl_clk, .ctl_wr, .ctl_addr);
	// 200 mhz clock
	always #2.5 mclk = ~mclk;
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask
	// one apb transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) miscompares++;
	endtask
	task automatic ctrl();
		apb(1'b1, LPS_CTRL_OFS, 32'({rev, alt, fast, rxen, txen}));
	endtask
	// stored word: shape marks set, bank, half and count; preset at 3, clear in diag
	function automatic logic [11:0] word_of(input logic [14:0] i);
		return {i[9:0] == 10'h3, i[12:11] == 2'h3 && i[9:0] == 10'h3fe, i[1], i[10] ^ i[0],
			~i[0], {i[14:10], i[1:0]} ^ 7'h2a};
	endfunction
	function automatic logic up(input logic [10:0] c);
		return (rev >= LPS_REV_SPLIT) ? (txb & sh_en) : c[10];
	endfunction
	function automatic logic [10:0] nxt(input logic [10:0] c);
		logic [10:0] lim;
		logic [11:0] w;
		lim = (rev >= LPS_REV_SPLIT) ? LPS_LIM_1K : LPS_LIM_2K;
		w = word_of({e_set, e_bank, up(c), c[9:0]});
		if (e_bank == 2'h0 || w[LPS_W_CLR]) return 11'h0;
		if (w[LPS_W_PRE]) return 11'h7fd & lim;
		if (c >= lim) return 11'h0;
		return c + 11'h1;
	endfunction
	// wait for a step, then let word fetch and output registers settle
	task automatic wait_tick();
		int n;
		n = 0;
		do begin @(posedge mclk); n++; end while (step_tick !== 1'b1 && n < 400);
		if (n >= 400) miscompares++;
		repeat (10) @(posedge mclk);
	endtask
	task automatic chk_step(input logic [10:0] c);
		logic [11:0] w;
		logic        tbk, rbk, bb;
		wait_tick();
		apb(1'b0, LPS_STAT_OFS, 32'h0);
		w = word_of({e_set, e_bank, up(c), c[9:0]});
		tbk = e_bank == 2'h2 && txb && sh_en;
		rbk = e_bank == 2'h2 && rxb && rxen;
		bb = (rev >= LPS_REV_SPLIT) & txb & sh_en;
		chk("status", 32'({bb, e_set, e_bank, e_bank, c}), q);
		chk("outputs", 32'({tbk ? 7'h0 : w[6:0], w[LPS_W_TX] & ~tbk, w[LPS_W_RX] & ~rbk,
			w[LPS_W_PHASE], bb}), 32'({shape_word_bus, tx_pulse, rx_pulse, phase_sel,
			blank_bank_select}));
		chk("phase word", 32'(w[LPS_W_PHASE] ? ph_hi : ph_lo), 32'(synth_phase_word));
	endtask
	// walk k steps from count c0, taking the shadowed enable at each restart
	task automatic chk_run(input logic [10:0] c0, input int k);
		logic [10:0] c, nc;
		c = c0;
		repeat (k) begin
			nc = nxt(c);
			if (nc != c + 11'h1) sh_en = txen;
			c = nc;
			chk_step(c);
		end
	endtask
	// wait for a restart into the expected bank and set
	task automatic sync0();
		int n;
		n = 0;
		do begin wait_tick(); apb(1'b0, LPS_STAT_OFS, 32'h0); n++; end
		while (!(q[10:0] === 11'h0 && q[12:11] === e_bank && q[16:15] === e_set) && n < 40);
		if (n >= 40) miscompares++;
		sh_en = txen;
	endtask
	// watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge mclk);
		miscompares++;
		complete_run();
	end
	initial begin
		int n;
		repeat (8) @(posedge mclk);
		chk("reset outputs", 32'h4000, 32'({tx_route_normal, d2_tx_enable, d2_lo_enable,
			fast_amp_power, blank_bank_select, step_tick, tx_pulse, rx_pulse, shape_word_bus}));
		sys_rst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("d2 enables", 32'h3, 32'({d2_tx_enable, d2_lo_enable}));
		ctrl();
		apb(1'b0, LPS_CTRL_OFS, 32'h0);
		chk("ctrl readback", 32'h23, q);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped error", 32'h1, 32'(e));
		apb(1'b1, LPS_PRESET_OFS, 32'h7fd);
		// fill the words each walk visits, both halves, all banks, two sets
		for (int s = 0; s < 2; s++)
			for (int b = 0; b < 8; b++)
				foreach (cl[k]) begin
					apb(1'b1, LPS_MADDR_OFS, 32'({s[1:0], b[2:0], cl[k]}));
					apb(1'b1, LPS_MDATA_OFS, 32'(word_of({s[1:0], b[2:0], cl[k]})));
				end
		// a data write steps the index; words and preset read back as written
		apb(1'b1, LPS_MADDR_OFS, 32'h0803);
		apb(1'b1, LPS_MDATA_OFS, 32'(word_of(15'h0803)));
		apb(1'b0, LPS_MADDR_OFS, 32'h0);
		chk("index step", 32'h0804, q);
		apb(1'b1, LPS_MADDR_OFS, 32'h0803);
		apb(1'b0, LPS_MDATA_OFS, 32'h0);
		chk("word readback", 32'(word_of(15'h0803)), q);
		apb(1'b0, LPS_PRESET_OFS, 32'h0);
		chk("preset readback", 32'h7fd, q);
		wait_tick();
		n = 10;
		do begin @(posedge mclk); n++; end while (step_tick !== 1'b1 && n < 400);
		chk("step period", 32'd200, 32'(n));
		sync0();
		chk_run(11'h0, 2);
		e_bank = 2'h2;
		far.send_bank(2'h2);
		sync0();
		chk_run(11'h0, 8);
		rev = 3'h0;
		ctrl();
		sync0();
		chk_run(11'h0, 8);
		rev = 3'h2;
		ctrl();
		far.set_blank(1'b1, 1'b1);
		{txb, rxb} = 2'b11;
		sync0();
		chk_run(11'h0, 8);
		e_bank = 2'h3;
		far.send_bank(2'h3);
		sync0();
		chk_run(11'h0, 1);
		txen = 1'b0;
		ctrl();
		chk("held blank select", 32'h1, 32'(blank_bank_select));
		chk_run(11'h1, 6);
		far.set_blank(1'b0, 1'b0);
		{txb, rxb} = 2'b00;
		far.ctl_send(LPS_CB_LEVEL, 8'ha5);
		far.ctl_send(3'h5, 8'h3c);
		chk("level word", 32'ha5, 32'(level_control_voltage));
		foreach (cl[k])
			if (k < 4) far.ctl_send(LPS_CB_FREQ, 8'h12 + 8'(k) * 8'h22);
		chk("freq word", 32'h12345678, synth_freq_word);
		far.ctl_send(LPS_CB_PHASE, 8'hab);
		far.ctl_send(LPS_CB_PHASE, 8'hc1);
		far.ctl_send(LPS_CB_PHASE, 8'h23);
		{ph_hi, ph_lo} = 24'habc123;
		rev = 3'h5;
		pulse_set_sel <= 2'h1;
		{e_set, e_bank} = 4'h5;
		ctrl();
		far.send_bank(2'h1);
		sync0();
		chk_run(11'h0, 8);
		{fast, alt} = 2'b11;
		ctrl();
		repeat (4) @(posedge mclk);
		chk("mode lines", 32'h18, 32'({fast_amp_power, tx_route_fast, tx_route_normal,
			d2_tx_enable, d2_lo_enable}));
		{fast, alt} = 2'b00;
		ctrl();
		repeat (4) @(posedge mclk);
		chk("mode lines off", 32'h07, 32'({fast_amp_power, tx_route_fast, tx_route_normal,
			d2_tx_enable, d2_lo_enable}));
		complete_run();
	end
endmodule // tb
